/* File: inc/rsp_pkg.sv */
// Constants for the register slave port
package rsp_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam logic PSEL_HIGH = 1'b1;
  localparam logic PSEL_LOW = 1'b0;
  localparam logic [1:0] SIZE_ACK_IDLE = 2'h3;
  localparam logic [1:0] SIZE_ACK_DONE = 2'h0;
  localparam int REG_COUNT = 64;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam int SEL_REQ_GAP = 2;
  typedef enum logic [3:0] {
    RSP_IDLE = 4'h1,
    RSP_ACCESS = 4'h2,
    RSP_ACK = 4'h4,
    RSP_WAIT = 4'h8
  } rsp_state_t;
endpackage : rsp_pkg

/* File: src/rsp_register_slave_port.sv */
// Register slave port with strobe-latched address and cycle acknowledge
//
// Operation
// - Address strobe marks valid register number; device captures it then.
// - Protocol select high: register number captured on strobe falling edge.
// - Protocol select low: register number captured on strobe rising edge.
// - On reads data strobe lets device drive selected register onto bus.
// - Device drives slave/memory acknowledge low once registers available.
// - Protocol select high: both data-size acknowledges low end the cycle.
// - Protocol select low: ready output asserted ends the slave cycle.
`timescale 1ns/1ps
module rsp_register_slave_port #(
  parameter int ADDR_W = rsp_pkg::ADDR_W,
  parameter int DATA_W = rsp_pkg::DATA_W
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic BUS_PROTOCOL_SELECT,
  input wire logic CHIP_SELECT_N,
  input wire logic SHARED_MEMORY_REQUEST_N,
  input wire logic [ADDR_W-1:0] REGISTER_NUMBER,
  input wire logic SLAVE_ADDRESS_STROBE_N,
  input wire logic SLAVE_DATA_STROBE_N,
  input wire logic SLAVE_DIR,
  input wire logic [DATA_W-1:0] DATA_IN,
  output logic [DATA_W-1:0] DATA_OUT,
  output logic DATA_OE,
  output logic SLAVE_MEMORY_ACKNOWLEDGE_N,
  output logic [1:0] DATA_SIZE_ACKNOWLEDGE_N,
  output logic DATA_SIZE_ACKNOWLEDGE_OE,
  output logic READY_OUT,
  output logic READY_OUT_OE,
  output logic COLLISION_ERROR
);
  localparam int NREG = 1 << ADDR_W;

  // Two-stage synchronisers
  logic [ADDR_W+5:0] sync1_reg;
  logic [ADDR_W+5:0] sync2_reg;
  logic mode;
  logic cs_act;
  logic mem_req_act;
  logic addr_strobe_n;
  logic data_strobe_act;
  logic dir;
  logic [ADDR_W-1:0] ra;
  logic addr_strobe_prev_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;
  logic [DATA_W-1:0] wdata_s1_reg;
  logic [DATA_W-1:0] wdata_s2_reg;
  logic [DATA_W-1:0] regs_reg [NREG];
  logic [DATA_W-1:0] regs_next [NREG];
  rsp_pkg::rsp_state_t state_reg;
  rsp_pkg::rsp_state_t state_next;
  logic [DATA_W-1:0] dout_reg;
  logic [DATA_W-1:0] dout_next;
  logic doe_reg;
  logic doe_next;
  logic slave_ack_n_reg;
  logic slave_ack_n_next;
  logic [1:0] size_ack_n_reg;
  logic [1:0] size_ack_n_next;
  logic size_ack_oe_reg;
  logic size_ack_oe_next;
  logic rdy_reg;
  logic rdy_next;
  logic rdy_oe_reg;
  logic rdy_oe_next;
  logic coll_reg;
  logic coll_next;
  logic is_read;

  function automatic logic dir_is_read(input logic m, input logic d);
    return (m == rsp_pkg::PSEL_HIGH) ? d : !d;
  endfunction : dir_is_read

  assign mode = sync2_reg[0];
  assign cs_act = !sync2_reg[1];
  assign mem_req_act = !sync2_reg[2];
  assign addr_strobe_n = sync2_reg[3];
  assign data_strobe_act = !sync2_reg[4];
  assign dir = sync2_reg[5];
  assign ra = sync2_reg[ADDR_W+5:6];
  assign is_read = dir_is_read(mode, dir);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
      wdata_s1_reg <= '0;
      wdata_s2_reg <= '0;
      addr_strobe_prev_reg <= 1'b1;
    end else begin
      sync1_reg <= {REGISTER_NUMBER, SLAVE_DIR,
                    SLAVE_DATA_STROBE_N, SLAVE_ADDRESS_STROBE_N,
                    SHARED_MEMORY_REQUEST_N, CHIP_SELECT_N,
                    BUS_PROTOCOL_SELECT};
      sync2_reg <= sync1_reg;
      wdata_s1_reg <= DATA_IN;
      wdata_s2_reg <= wdata_s1_reg;
      addr_strobe_prev_reg <= addr_strobe_n;
    end
  end

  // Address capture on the mode-selected strobe edge
  always_comb begin
    addr_next = addr_reg;
    if (mode == rsp_pkg::PSEL_HIGH && addr_strobe_prev_reg &&
        !addr_strobe_n) begin
      addr_next = ra;
    end else if (mode == rsp_pkg::PSEL_LOW && !addr_strobe_prev_reg &&
                 addr_strobe_n) begin
      addr_next = ra;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      addr_reg <= '0;
    end else begin
      addr_reg <= addr_next;
    end
  end

  // Access sequencing and register store
  always_comb begin
    state_next = state_reg;
    regs_next = regs_reg;
    dout_next = dout_reg;
    doe_next = 1'b0;
    slave_ack_n_next = 1'b1;
    size_ack_n_next = rsp_pkg::SIZE_ACK_IDLE;
    size_ack_oe_next = 1'b0;
    rdy_next = 1'b0;
    rdy_oe_next = 1'b0;
    coll_next = coll_reg | (cs_act & mem_req_act);
    unique case (state_reg)
      rsp_pkg::RSP_IDLE: begin
        if (cs_act && !mem_req_act) begin
          slave_ack_n_next = 1'b0;
          state_next = rsp_pkg::RSP_ACCESS;
        end
      end
      rsp_pkg::RSP_ACCESS: begin
        slave_ack_n_next = 1'b0;
        if (!cs_act) begin
          state_next = rsp_pkg::RSP_IDLE;
        end else if (data_strobe_act) begin
          if (is_read) begin
            dout_next = regs_reg[addr_reg];
            doe_next = 1'b1;
          end else begin
            regs_next[addr_reg] = wdata_s2_reg;
          end
          state_next = rsp_pkg::RSP_ACK;
        end
      end
      rsp_pkg::RSP_ACK: begin
        slave_ack_n_next = 1'b0;
        doe_next = is_read;
        if (mode == rsp_pkg::PSEL_HIGH) begin
          size_ack_n_next = rsp_pkg::SIZE_ACK_DONE;
          size_ack_oe_next = 1'b1;
        end else begin
          rdy_next = 1'b1;
          rdy_oe_next = 1'b1;
        end
        if (!cs_act || !data_strobe_act) begin
          state_next = rsp_pkg::RSP_WAIT;
        end
      end
      rsp_pkg::RSP_WAIT: begin
        if (mode == rsp_pkg::PSEL_HIGH) begin
          size_ack_oe_next = 1'b1;
        end else begin
          rdy_oe_next = 1'b1;
        end
        if (cs_act && !data_strobe_act) begin
          slave_ack_n_next = 1'b0;
          state_next = rsp_pkg::RSP_ACCESS;
        end else if (!cs_act) begin
          state_next = rsp_pkg::RSP_IDLE;
        end
      end
      default: begin
        state_next = rsp_pkg::RSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg <= rsp_pkg::RSP_IDLE;
      for (int i = 0; i < NREG; i++) begin
        regs_reg[i] <= rsp_pkg::REG_RESET;
      end
      dout_reg <= '0;
      doe_reg <= 1'b0;
      slave_ack_n_reg <= 1'b1;
      size_ack_n_reg <= rsp_pkg::SIZE_ACK_IDLE;
      size_ack_oe_reg <= 1'b0;
      rdy_reg <= 1'b0;
      rdy_oe_reg <= 1'b0;
      coll_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      regs_reg <= regs_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
      slave_ack_n_reg <= slave_ack_n_next;
      size_ack_n_reg <= size_ack_n_next;
      size_ack_oe_reg <= size_ack_oe_next;
      rdy_reg <= rdy_next;
      rdy_oe_reg <= rdy_oe_next;
      coll_reg <= coll_next;
    end
  end

  assign DATA_OUT = dout_reg;
  assign DATA_OE = doe_reg;
  assign SLAVE_MEMORY_ACKNOWLEDGE_N = slave_ack_n_reg;
  assign DATA_SIZE_ACKNOWLEDGE_N = size_ack_n_reg;
  assign DATA_SIZE_ACKNOWLEDGE_OE = size_ack_oe_reg;
  assign READY_OUT = rdy_reg;
  assign READY_OUT_OE = rdy_oe_reg;
  assign COLLISION_ERROR = coll_reg;
endmodule : rsp_register_slave_port

/* File: verification/rsp_chk.sv */
// Port checker for the register slave port
`timescale 1ns/1ps
module rsp_chk (
  input wire logic CLK,
  input wire logic RST,
  input wire logic BUS_PROTOCOL_SELECT,
  input wire logic CHIP_SELECT_N,
  input wire logic SHARED_MEMORY_REQUEST_N,
  input wire logic SLAVE_DATA_STROBE_N,
  input wire logic SLAVE_DIR,
  input wire logic DATA_OE,
  input wire logic SLAVE_MEMORY_ACKNOWLEDGE_N,
  input wire logic [1:0] DATA_SIZE_ACKNOWLEDGE_N,
  input wire logic DATA_SIZE_ACKNOWLEDGE_OE,
  input wire logic READY_OUT,
  input wire logic READY_OUT_OE,
  input wire logic COLLISION_ERROR
);
  wire logic m = BUS_PROTOCOL_SELECT;
  wire logic cs_n = CHIP_SELECT_N;
  wire logic ds_n = SLAVE_DATA_STROBE_N;
  wire logic [1:0] dk_n = DATA_SIZE_ACKNOWLEDGE_N;
  wire logic rdy = READY_OUT;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_slave_ack_sel: assert property (
    $fell(cs_n) && SHARED_MEMORY_REQUEST_N |->
    ##[1:4] !SLAVE_MEMORY_ACKNOWLEDGE_N) else $error("no slave ack");
  a_slave_ack_idle: assert property (
    cs_n [*5] |-> SLAVE_MEMORY_ACKNOWLEDGE_N) else $error("stray slave ack");
  a_size_ack_done: assert property (
    $fell(ds_n) && !cs_n && m |-> ##[2:8]
    (dk_n == 2'h0 && DATA_SIZE_ACKNOWLEDGE_OE)) else $error("no size ack");
  a_ready_drive: assert property (
    rdy |-> READY_OUT_OE) else $error("ready undriven");
  a_ready_done: assert property (
    $fell(ds_n) && !cs_n && !m |-> ##[2:8] rdy) else $error("no ready");
  a_ack_release: assert property (
    $rose(ds_n) |-> ##[1:4] (dk_n == 2'h3 && !rdy)) else $error("ack stuck");
  a_mode_quiet: assert property (
    (m [*3] |-> !rdy) and (!m [*3] |-> dk_n == 2'h3))
    else $error("wrong ack kind");
  a_read_drive: assert property (
    $rose(DATA_OE) |-> !ds_n && !cs_n && SLAVE_DIR == m)
    else $error("bad drive");
  a_clash_sticky: assert property (
    COLLISION_ERROR |=> COLLISION_ERROR) else $error("clash cleared");
  c_size_ack: cover property (dk_n == 2'h0);
  c_ready: cover property (rdy);
  c_clash: cover property (COLLISION_ERROR);
endmodule : rsp_chk

/* File: verification/rsp_host.sv */
// Host bus model driving register cycles
`timescale 1ns/1ps
module rsp_host (
  input wire logic CLK,
  input wire logic ack,
  output logic md,
  output logic cs_n,
  output logic mr_n,
  output logic [5:0] ra,
  output logic astb_n,
  output logic dstb_n,
  output logic dir,
  output logic [15:0] dq
);
  initial begin
    {md, cs_n, mr_n, astb_n, dstb_n, dir, ra, dq} = 28'hFFFFFFF;
  end
  task automatic cyc(input logic m, rd, input logic [5:0] a,
    input logic [15:0] d);
    int n;
    @(negedge CLK);
    md = m;
    repeat (3) @(negedge CLK);
    cs_n = 1'b0;
    astb_n = 1'b0;
    ra = m ? a : ~a;
    dir = rd ~^ m;
    dq = d;
    @(negedge CLK);
    // Strobe rises before the data strobe in both modes
    astb_n = 1'b1;
    ra = m ? ~a : a;
    @(negedge CLK);
    dstb_n = 1'b0;
    @(negedge CLK);
    ra = ~a;
    for (n = 0; n < 20 && !ack; n++) @(negedge CLK);
    dstb_n = 1'b1;
    dq = ~d;
    for (n = 0; n < 20 && ack; n++) @(negedge CLK);
    {cs_n, astb_n} = 2'h3;
    repeat (4) @(negedge CLK);
  endtask : cyc
  task automatic clash;
    @(negedge CLK);
    {cs_n, mr_n} = 2'h0;
    repeat (8) @(negedge CLK);
  endtask : clash
endmodule : rsp_host

/* File: verification/tb_register_slave_port.sv */
// Testbench for the register slave port
`timescale 1ns/1ps
module tb_register_slave_port;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic md, cs_n, mr_n, astb_n, dstb_n, dir, doe, smk_n, dk_oe, rdy;
  logic rdy_oe, col;
  logic ack_d = 1'b0;
  logic [5:0] ra, a, b;
  logic [15:0] dq, dout, d;
  logic [1:0] dk_n;
  logic [15:0] q[$];
  logic [15:0] mem[64];
  int n_fail = 0;
  int tests_run = 0;
  int seed = 32'haf433d3f;
  wire logic ack = md ? dk_n === 2'h0 && dk_oe === 1'b1 :
    rdy === 1'b1 && rdy_oe === 1'b1;
  always #5 CLK = ~CLK;
  rsp_host host (.CLK(CLK), .ack(ack), .md(md), .cs_n(cs_n), .mr_n(mr_n),
    .ra(ra), .astb_n(astb_n), .dstb_n(dstb_n), .dir(dir), .dq(dq));
  rsp_register_slave_port uut (.CLK(CLK), .RST(RST),
    .BUS_PROTOCOL_SELECT(md), .CHIP_SELECT_N(cs_n),
    .SHARED_MEMORY_REQUEST_N(mr_n), .REGISTER_NUMBER(ra),
    .SLAVE_ADDRESS_STROBE_N(astb_n), .SLAVE_DATA_STROBE_N(dstb_n),
    .SLAVE_DIR(dir), .DATA_IN(dq), .DATA_OUT(dout), .DATA_OE(doe),
    .SLAVE_MEMORY_ACKNOWLEDGE_N(smk_n), .DATA_SIZE_ACKNOWLEDGE_N(dk_n),
    .DATA_SIZE_ACKNOWLEDGE_OE(dk_oe), .READY_OUT(rdy),
    .READY_OUT_OE(rdy_oe), .COLLISION_ERROR(col));
  task automatic chk(input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("fails=%0d tests=%0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  always @(posedge CLK) begin
    ack_d <= ack;
    if (ack && !ack_d && doe === 1'b1) chk(dout, q.pop_front());
  end
  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
    repeat (12) @(negedge CLK);
    RST = 1'b0;
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 12; k++) begin
        a = k < 2 ? {6{k[0]}} : 6'($random(seed));
        b = 6'($random(seed));
        d = 16'($random(seed));
        q.push_back(mem[b]);
        host.cyc(m[0], 1'b1, b, ~d);
        host.cyc(m[0], 1'b0, a, d);
        mem[a] = d;
        q.push_back(d);
        host.cyc(m[0], 1'b1, a, 16'h0000);
      end
    end
    host.clash();
    chk(16'(col), 16'h0001);
    RST = 1'b1;
    {host.cs_n, host.mr_n} = 2'h3;
    repeat (3) @(negedge CLK);
    RST = 1'b0;
    chk(16'(col), 16'h0000);
    q.push_back(16'h0000);
    host.cyc(1'b1, 1'b1, a, 16'h1234);
    chk(16'(q.size()), 16'h0000);
    report_and_stop();
  end
endmodule : tb_register_slave_port
bind rsp_register_slave_port rsp_chk chk_i (.CLK(CLK), .RST(RST),
  .BUS_PROTOCOL_SELECT(BUS_PROTOCOL_SELECT),
  .CHIP_SELECT_N(CHIP_SELECT_N),
  .SHARED_MEMORY_REQUEST_N(SHARED_MEMORY_REQUEST_N),
  .SLAVE_DATA_STROBE_N(SLAVE_DATA_STROBE_N), .SLAVE_DIR(SLAVE_DIR),
  .DATA_OE(DATA_OE),
  .SLAVE_MEMORY_ACKNOWLEDGE_N(SLAVE_MEMORY_ACKNOWLEDGE_N),
  .DATA_SIZE_ACKNOWLEDGE_N(DATA_SIZE_ACKNOWLEDGE_N),
  .DATA_SIZE_ACKNOWLEDGE_OE(DATA_SIZE_ACKNOWLEDGE_OE),
  .READY_OUT(READY_OUT), .READY_OUT_OE(READY_OUT_OE),
  .COLLISION_ERROR(COLLISION_ERROR));
